// [verilog/pcs_consts.svh]
// constants for the program counter, stack and status core
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH
`define PCS_RESET_VECTOR   11'h000
`define PCS_INT_VECTOR     11'h004
`define PCS_ADDR_STATUS    9'h003
`define PCS_ADDR_STATUS_B1 9'h083
`define PCS_ADDR_STATUS_B2 9'h103
`define PCS_ADDR_STATUS_B3 9'h183
`define PCS_ADDR_PROG_LOW  7'h02
`define PCS_ADDR_UPPER     7'h0A
`define PCS_ADDR_TABLE     9'h18C
`define PCS_TABLE_LOW_CMD  8'h01
`define PCS_TABLE_HIGH_CMD 8'h02
`define PCS_EE_KEY         8'hE2
`define PCS_STATUS_RESET   8'h00
`define PCS_TABLE_RESET    8'h00
`define PCS_BIT_IBANK      7
`define PCS_BIT_BANK_HI    6
`define PCS_BIT_BANK_LO    5
`define PCS_BIT_TIMEOUT    4
`define PCS_BIT_PDOWN      3
`define PCS_BIT_ZERO       2
`define PCS_BIT_DCARRY     1
`define PCS_BIT_CARRY      0
`define PCS_STACK_DEPTH    8
`endif

// [verilog/pcs_pkg.sv]
// types for the program counter, stack and status core
package pcs_pkg;
    // alu operations
    typedef enum logic [3:0] {
        PCS_ALU_PASS_B, PCS_ALU_ADD, PCS_ALU_SUB, PCS_ALU_AND, PCS_ALU_OR,
        PCS_ALU_XOR, PCS_ALU_RLC, PCS_ALU_RRC, PCS_ALU_COM, PCS_ALU_INC, PCS_ALU_DEC
    } pcs_alu_op_t;
    // program flow action for the current instruction
    typedef enum logic [2:0] {
        PCS_FLOW_NEXT, PCS_FLOW_JUMP, PCS_FLOW_CALL, PCS_FLOW_RETURN,
        PCS_FLOW_INTERRUPT, PCS_FLOW_HOLD
    } pcs_flow_t;
    // table read request from an opcode
    typedef enum logic [1:0] {
        PCS_TBL_NONE, PCS_TBL_LOW, PCS_TBL_HIGH
    } pcs_tbl_t;
endpackage

// [verilog/pcs_core.sv]
// program counter, return stack, table read, alu and status register core
//
// Operation
// - eleven bit program address register
// - low byte data register, upper via latch
// - any reset clears upper address bits
// - reset vector 000h, interrupt vector 004h
// - address increments otherwise by one, hold flow keeps it
// - call and jump load full target
// - returns reload address from stack top
// - low byte write also loads upper bits from latch
// - stack eleven bits, eight entries, ordered
// - table opcodes read low or high byte into working register
// - table port write 01h/02h triggers read
// - key E2h routes port low read to eeprom
// - eight bit add, subtract, shift, logic
// - working register unaddressed, operand source
// - subtraction carries are inverted borrows
// - status mirrored in all four banks
// - flag writes ignored when logic updates
// - bits 6:5 select direct data bank
// - indirect bank bit selects banks 2/3
// - timeout flag cleared by resets, set on timeout
// - powerdown flag cleared by resets, sleep sets
// - zero flag follows result
`timescale 1ns/1ns
`include "pcs_consts.svh"

module pcs_core (
    input  wire logic                 i_ref_clk,       // system clock, 10 MHz
    input  wire logic                 i_rst,           // any reset source, sync high
    input  wire logic                 i_por,           // power-on or low-voltage reset pulse
    input  wire logic                 i_step,          // one instruction completes this cycle
    input  wire pcs_pkg::pcs_flow_t   i_flow,          // flow action of the instruction
    input  wire logic [10:0]          i_target,        // call/jump target from instruction word
    input  wire pcs_pkg::pcs_alu_op_t i_alu_op,        // alu operation
    input  wire logic                 i_use_imm,       // operand b is the immediate
    input  wire logic [7:0]           i_imm,           // immediate constant
    input  wire logic [7:0]           i_file_rd,       // file register operand
    input  wire logic                 i_flag_upd,      // instruction updates z/dc/c
    input  wire logic                 i_zero_only,     // instruction updates z only
    input  wire logic                 i_dest_w,        // result goes to working register
    input  wire logic                 i_dest_f,        // result written to file address
    input  wire logic                 i_w_load,        // load working register with i_imm
    input  wire logic [8:0]           i_f_addr,        // direct 7 bit address with bank
    input  wire logic                 i_wr_en,         // plain register write strobe
    input  wire logic [7:0]           i_wr_data,       // plain register write data
    input  wire logic [8:0]           i_rd_addr,       // register read address
    input  wire pcs_pkg::pcs_tbl_t    i_tbl_op,        // table opcode in this instruction
    input  wire logic [15:0]          i_rom_data,      // program word at o_rom_addr
    input  wire logic [7:0]           i_ee_data,       // eeprom data byte
    input  wire logic [7:0]           i_ee_key,        // eeprom access key register
    input  wire logic [10:0]          i_data_pointer,  // data_pointer_high:data_pointer_low
    input  wire logic [7:0]           i_upper_addr_latch, // upper address latch
    input  wire logic [7:0]           i_indirect_pointer, // indirect pointer register
    input  wire logic                 i_watchdog_clear_op, // watchdog clear executed
    input  wire logic                 i_sleep_op,      // sleep executed
    input  wire logic                 i_wdt_timeout,   // watchdog time out pulse
    output logic [10:0]               o_prog_addr,     // program address
    output logic [10:0]               o_rom_addr,      // program memory table address
    output logic [7:0]                o_w,             // working register
    output logic [7:0]                o_status,        // status register
    output logic [7:0]                o_rd_data,       // read data for core registers
    output logic [8:0]                o_dir_addr,      // banked direct data address
    output logic [8:0]                o_ind_addr,      // banked indirect data address
    output logic [7:0]                o_alu_result     // alu result
);
    import pcs_pkg::*;

    // ************************************************
    // declarations
    // ************************************************
    logic [10:0] prog_addr;                       // program address register
    logic [10:0] stack_mem [`PCS_STACK_DEPTH];    // return stack
    logic [2:0]  stack_ptr;                       // next free entry
    logic [7:0]  w_reg;                           // working register
    logic [7:0]  status;                          // status register
    logic [7:0]  table_read_port;                 // table read result
    logic [7:0]  next_result;                     // alu output
    logic        next_carry;                      // alu carry out
    logic        next_dcarry;                     // alu digit carry out
    logic [7:0]  op_b;                            // second operand
    logic [8:0]  sum9;                            // nine bit sum
    logic [4:0]  sum5;                            // nibble sum
    logic        wr_prog_low;                     // write hits low program address
    logic        wr_status;                       // write hits status
    logic        wr_table;                        // write hits table port
    logic [7:0]  wdata;                           // effective register write data
    logic        wen;                             // effective register write enable
    logic [10:0] stack_top;                       // top entry

    // top entry sits one below the next free slot
    assign stack_top = stack_mem[3'(stack_ptr - 3'h1)];
    // second operand: immediate or file register
    assign op_b      = i_use_imm ? i_imm : i_file_rd;
    // a step that writes a file register shares the plain write path
    assign wen       = i_wr_en | (i_step & i_dest_f);
    assign wdata     = (i_step & i_dest_f) ? next_result : i_wr_data;
    // only the low seven bits decode, so every bank sees the mirrors
    assign wr_prog_low = wen & (i_f_addr[6:0] == `PCS_ADDR_PROG_LOW);
    assign wr_status   = wen & (i_f_addr[6:0] == 7'(`PCS_ADDR_STATUS));
    // the table port decodes the full nine bit address
    assign wr_table    = wen & (i_f_addr == `PCS_ADDR_TABLE);

    // ************************************************
    // alu
    // ************************************************
    // eight bit datapath; subtract uses b + ~w + 1 so carries are inverted borrows
    always_comb begin
        sum9        = 9'h000;
        sum5        = 5'h00;
        next_result = 8'h00;
        next_carry  = status[`PCS_BIT_CARRY];
        next_dcarry = status[`PCS_BIT_DCARRY];
        case (i_alu_op)
            PCS_ALU_ADD: begin
                sum9        = {1'b0, o_w} + {1'b0, op_b};
                sum5        = {1'b0, o_w[3:0]} + {1'b0, op_b[3:0]};
                next_result = sum9[7:0];
                next_carry  = sum9[8];
                next_dcarry = sum5[4];
            end
            PCS_ALU_SUB: begin
                sum9        = {1'b0, op_b} + {1'b0, ~o_w} + 9'h001;
                sum5        = {1'b0, op_b[3:0]} + {1'b0, ~o_w[3:0]} + 5'h01;
                next_result = sum9[7:0];
                next_carry  = sum9[8];
                next_dcarry = sum5[4];
            end
            PCS_ALU_AND: next_result = o_w & op_b;
            PCS_ALU_OR:  next_result = o_w | op_b;
            PCS_ALU_XOR: next_result = o_w ^ op_b;
            PCS_ALU_RLC: begin
                next_result = {op_b[6:0], status[`PCS_BIT_CARRY]};
                next_carry  = op_b[7];
            end
            PCS_ALU_RRC: begin
                next_result = {status[`PCS_BIT_CARRY], op_b[7:1]};
                next_carry  = op_b[0];
            end
            PCS_ALU_COM: next_result = ~op_b;
            PCS_ALU_INC: next_result = 8'(op_b + 8'h01);
            PCS_ALU_DEC: next_result = 8'(op_b - 8'h01);
            default:     next_result = op_b;
        endcase
    end

    // ************************************************
    // program address and return stack
    // ************************************************
    // program address update, one step per instruction
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prog_addr <= `PCS_RESET_VECTOR;
        end else if (i_step) begin
            if (wr_prog_low) begin
                prog_addr <= {i_upper_addr_latch[2:0], wdata};
            end else begin
                case (i_flow)
                    PCS_FLOW_JUMP, PCS_FLOW_CALL: prog_addr <= i_target;
                    PCS_FLOW_RETURN:    prog_addr <= stack_top;
                    PCS_FLOW_INTERRUPT: prog_addr <= `PCS_INT_VECTOR;
                    PCS_FLOW_HOLD:      prog_addr <= prog_addr;
                    default:            prog_addr <= 11'(prog_addr + 11'h001);
                endcase
            end
        end
    end

    // stack pointer, wraps silently on overflow and underflow
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            stack_ptr <= 3'h0;
        end else if (i_step && !wr_prog_low) begin
            if (i_flow == PCS_FLOW_CALL || i_flow == PCS_FLOW_INTERRUPT) begin
                stack_ptr <= 3'(stack_ptr + 3'h1);
            end else if (i_flow == PCS_FLOW_RETURN) begin
                stack_ptr <= 3'(stack_ptr - 3'h1);
            end
        end
    end

    // stack storage, return address is the following instruction
    always_ff @(posedge i_ref_clk) begin
        if (i_step && !wr_prog_low) begin
            if (i_flow == PCS_FLOW_CALL) begin
                stack_mem[stack_ptr] <= 11'(prog_addr + 11'h001);
            // an interrupt saves the address it cut in on
            end else if (i_flow == PCS_FLOW_INTERRUPT) begin
                stack_mem[stack_ptr] <= prog_addr;
            end
        end
    end

    // ************************************************
    // working register
    // ************************************************
    // working register load from alu or literal
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            w_reg <= 8'h00;
        end else if (i_step) begin
            // table opcodes take priority over every other load
            if (i_tbl_op == PCS_TBL_LOW) begin
                w_reg <= i_rom_data[7:0];
            end else if (i_tbl_op == PCS_TBL_HIGH) begin
                w_reg <= i_rom_data[15:8];
            end else if (i_w_load || (i_flow == PCS_FLOW_RETURN && i_use_imm)) begin
                w_reg <= i_imm;
            end else if (i_dest_w) begin
                w_reg <= next_result;
            end
        end
    end

    // ************************************************
    // table read port
    // ************************************************
    // command write fetches the addressed byte
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            table_read_port <= `PCS_TABLE_RESET;
        end else if (wr_table) begin
            if (wdata == `PCS_TABLE_LOW_CMD) begin
                table_read_port <= (i_ee_key == `PCS_EE_KEY) ? i_ee_data : i_rom_data[7:0];
            end else if (wdata == `PCS_TABLE_HIGH_CMD) begin
                table_read_port <= i_rom_data[15:8];
            end
        end
    end

    // ************************************************
    // status register
    // ************************************************
    // flags from logic win over a direct write to the flag bits
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            status <= `PCS_STATUS_RESET;
        end else begin
            if (wr_status) begin
                // bank bits follow any write
                status[7:5] <= wdata[7:5];
                if (!(i_step && (i_flag_upd || i_zero_only))) begin
                    status[2:0] <= wdata[2:0];
                end
            end
            // zero follows every flag updating step
            if (i_step && (i_flag_upd || i_zero_only)) begin
                status[`PCS_BIT_ZERO] <= (next_result == 8'h00);
            end
            if (i_step && i_flag_upd) begin
                status[`PCS_BIT_CARRY]  <= next_carry;
                status[`PCS_BIT_DCARRY] <= next_dcarry;
            end
            // timeout: set wins over clear
            if (i_wdt_timeout) begin
                status[`PCS_BIT_TIMEOUT] <= 1'b1;
            end else if (i_por || i_watchdog_clear_op || i_sleep_op) begin
                status[`PCS_BIT_TIMEOUT] <= 1'b0;
            end
            // powerdown: set wins over clear
            if (i_sleep_op) begin
                status[`PCS_BIT_PDOWN] <= 1'b1;
            end else if (i_por || i_watchdog_clear_op) begin
                status[`PCS_BIT_PDOWN] <= 1'b0;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    // read mux: low program byte, status and table port
    always_comb begin
        o_rd_data = 8'h00;
        if (i_rd_addr[6:0] == 7'(`PCS_ADDR_STATUS)) begin
            o_rd_data = status;
        end else if (i_rd_addr[6:0] == `PCS_ADDR_PROG_LOW) begin
            o_rd_data = prog_addr[7:0];
        end else if (i_rd_addr == `PCS_ADDR_TABLE) begin
            o_rd_data = table_read_port;
        end
    end

    // banked data addresses and plain register views
    assign o_dir_addr   = {status[`PCS_BIT_BANK_HI], status[`PCS_BIT_BANK_LO], i_f_addr[6:0]};
    assign o_ind_addr   = {status[`PCS_BIT_IBANK], i_indirect_pointer};
    assign o_rom_addr   = i_data_pointer;
    assign o_prog_addr  = prog_addr;
    assign o_w          = w_reg;
    assign o_status     = status;
    assign o_alu_result = next_result;

    // ************************************************
    // assertions
    // ************************************************
    // a call step that is not a low byte write
    sequence s_call_taken;
        i_step && !wr_prog_low && i_flow == PCS_FLOW_CALL;
    endsequence

    // reset and vectors
    a_reset_vector: assert property (@(posedge i_ref_clk) i_rst |=> o_prog_addr == 11'h000)
        else $error("program address not cleared by reset");
    // program flow
    a_call_target: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_call_taken |=> o_prog_addr == $past(i_target))
        else $error("call target not loaded");
    a_call_return: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_call_taken ##1 (i_step && !wr_prog_low && i_flow == PCS_FLOW_RETURN)
        |=> o_prog_addr == $past(o_prog_addr, 2) + 11'h001)
        else $error("return did not restore address");
    a_int_vector: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_step && !wr_prog_low && i_flow == PCS_FLOW_INTERRUPT) |=> o_prog_addr == 11'h004)
        else $error("interrupt vector wrong");
    a_pc_increment: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_step && !wr_prog_low && i_flow == PCS_FLOW_NEXT)
        |=> o_prog_addr == 11'($past(o_prog_addr) + 11'h001))
        else $error("program address did not advance");
    a_low_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_step && wr_prog_low) |=> o_prog_addr[10:8] == $past(i_upper_addr_latch[2:0]))
        else $error("upper bits not from latch");
    // status flags
    a_zero_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_step && i_flag_upd) |=> o_status[2] == ($past(next_result) == 8'h00))
        else $error("zero flag wrong");
    a_sleep_pdown: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_sleep_op |=> o_status[3] && !o_status[4] || $past(i_wdt_timeout))
        else $error("sleep did not set power down");
    a_timeout_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_wdt_timeout |=> o_status[4])
        else $error("timeout flag not set");
    // table port and banks
    a_table_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (wr_table && wdata == 8'h01 && i_ee_key != 8'hE2) |=> o_rd_data == $past(i_rom_data[7:0])
        || i_rd_addr != 9'h18C)
        else $error("table low read wrong");
    a_indirect_bank: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        wr_status |=> o_ind_addr[8] == $past(wdata[7]))
        else $error("indirect bank wrong");

endmodule // pcs_core

// [dv/pcs_flash_model.sv]
// program flash model that answers the core's table reads
`timescale 1ns/1ns
module pcs_flash_model (
    input  wire logic [10:0] i_addr,  // word address over the whole 2K space
    output logic      [15:0] o_word   // program word held at that address
);
    // ************************************************
    // program memory contents
    // ************************************************
    // each word is derived from its address, so the two byte lanes differ at every address but eight
    // and a swapped or stale lane shows up at once
    assign o_word = {i_addr[10:3] + 8'h19, i_addr[7:0] ^ 8'hC3};
endmodule // pcs_flash_model

// [dv/pcs_core_tb.sv]
// self-checking testbench for the program counter, stack and status core
`timescale 1ns/1ns
module pcs_core_tb;
    import pcs_pkg::*;
    // ************************************************
    // stimulus, observation and bench state
    // ************************************************
    logic i_ref_clk = 0, i_rst = 1, i_por = 0, i_step = 0, i_use_imm = 0, i_flag_upd = 0, i_zero_only = 0;
    logic i_dest_w = 0, i_dest_f = 0, i_w_load = 0, i_wr_en = 0, i_watchdog_clear_op = 0, i_sleep_op = 0;
    logic i_wdt_timeout = 0;
    pcs_flow_t   i_flow = PCS_FLOW_HOLD;
    pcs_alu_op_t i_alu_op = PCS_ALU_PASS_B;
    pcs_tbl_t    i_tbl_op = PCS_TBL_NONE;
    logic [10:0] i_target = '0, i_data_pointer = '0, o_prog_addr, o_rom_addr, ep, ex, rets [9];
    logic [7:0]  i_imm = '0, i_file_rd = '0, i_wr_data = '0, i_ee_data = '0, i_ee_key = '0, a, b, ew;
    logic [7:0]  i_upper_addr_latch = '0, i_indirect_pointer = '0, o_w, o_status, o_rd_data, o_alu_result;
    logic [8:0]  i_f_addr = '0, i_rd_addr = '0, o_dir_addr, o_ind_addr;
    logic [15:0] i_rom_data, rw;
    logic [31:0] seed = 32'h0000BC6E;  // fixed start keeps every run identical
    logic [2:0]  ef = 3'h0;            // expected z, dc, c
    int errors = 0, n_checks = 0;
    logic [8:0]  mirror [4] = '{9'h003, 9'h083, 9'h103, 9'h183};
    logic [3:0]  evs [8] = '{4'h8, 4'h4, 4'h2, 4'h8, 4'h4, 4'h1, 4'h6, 4'hC};  // sleep, timeout, clear, power-on
    logic [1:0]  tos [8] = '{2'h1, 2'h3, 2'h0, 2'h1, 2'h3, 2'h0, 2'h2, 2'h3};  // expected timeout, powerdown
    pcs_alu_op_t ops [11] = '{PCS_ALU_ADD, PCS_ALU_SUB, PCS_ALU_RLC, PCS_ALU_RRC, PCS_ALU_AND, PCS_ALU_OR,
                              PCS_ALU_XOR, PCS_ALU_COM, PCS_ALU_INC, PCS_ALU_DEC, PCS_ALU_PASS_B};
    // ************************************************
    // clock, design and flash model
    // ************************************************
    always #50 i_ref_clk = ~i_ref_clk;
    pcs_core dut (.i_ref_clk, .i_rst, .i_por, .i_step, .i_flow, .i_target, .i_alu_op, .i_use_imm, .i_imm,
        .i_file_rd, .i_flag_upd, .i_zero_only, .i_dest_w, .i_dest_f, .i_w_load, .i_f_addr, .i_wr_en,
        .i_wr_data, .i_rd_addr, .i_tbl_op, .i_rom_data, .i_ee_data, .i_ee_key, .i_data_pointer,
        .i_upper_addr_latch, .i_indirect_pointer, .i_watchdog_clear_op, .i_sleep_op, .i_wdt_timeout,
        .o_prog_addr, .o_rom_addr, .o_w, .o_status, .o_rd_data, .o_dir_addr, .o_ind_addr, .o_alu_result);
    pcs_flash_model flash (.i_addr(o_rom_addr), .o_word(i_rom_data));
    // ************************************************
    // expectation helpers
    // ************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // mirror of the flash contents
    function automatic logic [15:0] rom(input logic [10:0] ad);
        return {ad[10:3] + 8'h19, ad[7:0] ^ 8'hC3};
    endfunction
    // result and flags {res, z, dc, c}; logic ops leave dc and c alone
    function automatic logic [10:0] alu_exp(input pcs_alu_op_t op, input logic [7:0] wv, input logic [7:0] bv,
                                            input logic [1:0] cf);
        logic [8:0] r;
        logic       dc;
        dc = cf[1];
        case (op)
            PCS_ALU_ADD: begin
                r = {1'b0, wv} + {1'b0, bv};
                dc = ({1'b0, wv[3:0]} + {1'b0, bv[3:0]}) > 5'h0F;
            end
            PCS_ALU_SUB: begin  // carries read as inverted borrows
                r = {bv >= wv, bv - wv};
                dc = bv[3:0] >= wv[3:0];
            end
            PCS_ALU_RLC: r = {bv, cf[0]};
            PCS_ALU_RRC: r = {bv[0], cf[0], bv[7:1]};
            PCS_ALU_COM: r = {cf[0], ~bv};
            PCS_ALU_INC: r = {cf[0], 8'(bv + 8'h01)};
            PCS_ALU_DEC: r = {cf[0], 8'(bv - 8'h01)};
            PCS_ALU_PASS_B: r = {cf[0], bv};
            PCS_ALU_AND: r = {cf[0], wv & bv};
            PCS_ALU_OR:  r = {cf[0], wv | bv};
            default:     r = {cf[0], wv ^ bv};
        endcase
        return {r[7:0], r[7:0] == 8'h00, dc, r[8]};
    endfunction
    // ************************************************
    // comparison, stepping and closing tasks
    // ************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one edge takes the request and drops every strobe by non-blocking update
    task automatic tick;
        @(posedge i_ref_clk);
        {i_step, i_wr_en, i_flag_upd, i_zero_only, i_dest_w, i_dest_f, i_w_load, i_use_imm} <= '0;
        {i_sleep_op, i_wdt_timeout, i_watchdog_clear_op, i_por} <= '0;
        i_tbl_op <= PCS_TBL_NONE;
        i_flow <= PCS_FLOW_HOLD;
        @(negedge i_ref_clk);
    endtask
    task automatic do_step(input pcs_flow_t f);
        i_step = 1;
        i_flow = f;
        tick;
    endtask
    // a hang is cut short here
    initial begin
        #2000000;
        errors++;
        complete_run;
    end
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_rst = 0;
        i_rd_addr = 9'h18C;
        #1 chk(o_prog_addr, 11'h000);
        chk(o_status, 8'h00);
        chk(o_rd_data, 8'h00);
        do_step(PCS_FLOW_NEXT);
        chk(o_prog_addr, 11'h001);
        ep = 11'h001;
        // nine nested calls overrun the eight-deep stack, oldest entry is lost
        for (int i = 0; i < 9; i++) begin
            seed = xs(seed);
            rets[i] = ep + 11'h001;
            ep = seed[10:0];
            i_target = ep;
            do_step(PCS_FLOW_CALL);
            chk(o_prog_addr, ep);
        end
        for (int i = 8; i > 0; i--) begin
            i_use_imm = 1;
            i_imm = rets[i][7:0];
            do_step(PCS_FLOW_RETURN);
            chk(o_prog_addr, rets[i]);
            chk(o_w, rets[i][7:0]);
        end
        do_step(PCS_FLOW_INTERRUPT);
        chk(o_prog_addr, 11'h004);
        do_step(PCS_FLOW_RETURN);
        chk(o_prog_addr, rets[1]);
        // low byte write pulls the upper bits from the latch
        seed = xs(seed);
        {i_upper_addr_latch, i_wr_data} = seed[15:0];
        i_f_addr = 9'h002;
        i_wr_en = 1;
        do_step(PCS_FLOW_NEXT);
        i_rd_addr = 9'h002;
        #1 chk(o_prog_addr, seed[10:0]);
        chk(o_rd_data, seed[7:0]);
        // arithmetic and logic, file and immediate operands, one equal-operand subtract
        for (int i = 0; i < 33; i++) begin
            seed = xs(seed);
            a = seed[7:0];
            b = (i == 1) ? a : seed[15:8];
            i_imm = a;
            i_w_load = 1;
            do_step(PCS_FLOW_HOLD);
            chk(o_w, a);
            i_alu_op = ops[i % 11];
            i_use_imm = i[0];
            i_imm = b;
            i_file_rd = i[0] ? ~b : b;
            i_flag_upd = (i % 11) < 4;
            i_zero_only = (i % 11) >= 4;
            i_dest_w = 1;
            ex = alu_exp(ops[i % 11], a, b, ef[1:0]);
            #1 chk(o_alu_result, ex[10:3]);
            do_step(PCS_FLOW_HOLD);
            ef = ex[2:0];
            chk(o_w, ex[10:3]);
            chk(o_status[2:0], ef);
        end
        ew = ex[10:3];
        // every bank setting, read-only flags kept clear
        i_indirect_pointer = 8'h0F;
        for (int k = 0; k < 4; k++) begin
            i_wr_en = 1;
            i_f_addr = 9'h003;
            i_wr_data = {k[0], k[1:0], 5'h1F};
            tick;
            i_f_addr = 9'h012;
            #1 chk(o_status, {k[0], k[1:0], 5'h07});
            chk(o_dir_addr, {k[1:0], 7'h12});
            chk(o_ind_addr, {k[0], 8'h0F});
        end
        foreach (mirror[j]) begin
            i_rd_addr = mirror[j];
            #1 chk(o_rd_data, 8'hE7);
        end
        // status as destination of a flag-setting add keeps the logic's flags
        seed = xs(seed);
        i_alu_op = PCS_ALU_ADD;
        i_file_rd = seed[7:0];
        {i_flag_upd, i_dest_f} = 2'h3;
        i_f_addr = 9'h003;
        ex = alu_exp(PCS_ALU_ADD, ew, seed[7:0], 2'h3);
        do_step(PCS_FLOW_HOLD);
        chk(o_status, {ex[10:8], 2'h0, ex[2:0]});
        for (int k = 0; k < 8; k++) begin
            {i_sleep_op, i_wdt_timeout, i_watchdog_clear_op, i_por} = evs[k];
            tick;
            chk(o_status[4:3], tos[k]);
        end
        // table reads by opcode and through the port, key one off then on
        seed = xs(seed);
        i_data_pointer = seed[10:0];
        i_ee_data = seed[23:16];
        rw = rom(seed[10:0]);
        #1 chk(o_rom_addr, seed[10:0]);
        i_tbl_op = PCS_TBL_LOW;
        do_step(PCS_FLOW_HOLD);
        chk(o_w, rw[7:0]);
        i_tbl_op = PCS_TBL_HIGH;
        do_step(PCS_FLOW_HOLD);
        chk(o_w, rw[15:8]);
        i_rd_addr = 9'h18C;
        for (int k = 0; k < 3; k++) begin
            i_ee_key = (k == 2) ? 8'hE2 : 8'hE3;
            i_wr_en = 1;
            i_f_addr = 9'h18C;
            i_wr_data = (k == 1) ? 8'h02 : 8'h01;
            tick;
            #1 chk(o_rd_data, (k == 0) ? rw[7:0] : (k == 1) ? rw[15:8] : i_ee_data);
        end
        // jump to the top word, then a mid-run reset clears the upper bits again
        i_target = 11'h7FF;
        do_step(PCS_FLOW_JUMP);
        chk(o_prog_addr, 11'h7FF);
        i_rst = 1;
        tick;
        tick;
        i_rst = 0;
        #1 chk(o_prog_addr, 11'h000);
        chk(o_w, 8'h00);
        chk(o_rd_data, 8'h00);
        complete_run;
    end
endmodule // pcs_core_tb
